/* File: logic/tbc_dev.sv */
// module: device end that parses buffer commands and loads payload into the data fifo
`timescale 1ns/100ps
module tbc_dev
  import tbc_pkg::*;
#(
  parameter int unsigned DEPTH = TBC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // word link from the host controller
  tbc_if.dev                    link,
  // payload toward the transmitter
  output logic [TBC_W-1:0]      pay_data_out,
  output logic                  pay_valid_out,
  input  wire logic             pay_ready_in,
  // completion status per packet
  output logic [TBC_W-1:0]      stat_word_out,
  output logic                  stat_valid_out
);
  typedef enum logic [1:0] {S_A, S_B, S_PAY} tbc_dst_t;

  tbc_dst_t          st;
  logic [TBC_W-1:0]  cmd_a;
  logic [TBC_W-1:0]  b_ref;
  logic              in_pkt;
  logic              pkt_err;
  logic              err_flag;
  logic              done_flag;
  logic              irq;
  logic [TBC_BC_W-1:0] byte_cnt;
  tbc_dw_t           idx;
  tbc_dw_t           total;
  tbc_dw_t           padded;

  // decoded fields of the held first word
  logic              ioc;
  logic [1:0]        al;
  logic [4:0]        off;
  logic [10:0]       size;
  logic              first;
  logic              last;
  tbc_dw_t           first_dw;

  // per-cycle decisions
  logic              accept;
  logic              keep;
  logic              fifo_ready;
  logic              b_take;
  logic              tag_bad;
  logic              seq_bad;
  logic              b_err;
  tbc_dw_t           b_tot;
  tbc_dw_t           b_pad;
  logic [TBC_W-1:0]  cur_b;
  logic [TBC_BC_W-1:0] next_bytes;
  logic [TBC_BC_W-1:0] bytes_now;
  logic              buf_end;
  logic              pkt_done;
  logic              len_bad;
  logic              err_now;
  logic              eff_pkt_err;

  assign ioc      = cmd_a[TBC_IOC_BIT];
  assign al       = cmd_a[TBC_ALIGN_HI:TBC_ALIGN_LO];
  assign off      = cmd_a[TBC_OFF_HI:TBC_OFF_LO];
  assign size     = cmd_a[TBC_SIZE_HI:TBC_SIZE_LO];
  assign first    = cmd_a[TBC_FIRST];
  assign last     = cmd_a[TBC_LAST];
  // whole dwords ahead of the start offset carry no payload
  assign first_dw = {7'h0, off[4:2]};

  // only dwords with payload bytes go to the fifo; the rest are swallowed
  assign keep   = (st == S_PAY) && (idx >= first_dw) && (idx < total);
  // command and padding words are always taken, so only payload waits on the fifo
  assign link.word_ready = keep ? fifo_ready : 1'b1;
  assign accept = link.word_valid && link.word_ready;
  assign b_take = accept && (st == S_B);

  // second-word checks against the reference word of the packet
  assign tag_bad = b_take && !first && (link.word != b_ref);
  assign seq_bad = b_take && (first ? in_pkt : !in_pkt);
  assign b_err   = tag_bad || seq_bad;

  // buffer extent from the first word just held
  assign b_tot = tbc_buf_dwords(off, size);
  assign b_pad = tbc_padded(b_tot, al);

  // a packet reports its first buffer's tag, even when a later empty buffer ends it
  assign cur_b      = (b_take && first) ? link.word : b_ref;
  assign next_bytes = (first ? '0 : byte_cnt) + TBC_BC_W'(size);
  assign bytes_now  = (st == S_B) ? next_bytes : byte_cnt;

  // a buffer ends on its last padded dword, or at once when it is empty
  assign buf_end  = accept && (((st == S_B) && (b_pad == '0)) ||
                               ((st == S_PAY) && (idx == padded - 10'h001)));
  assign pkt_done = buf_end && last;
  assign len_bad  = pkt_done &&
                    (bytes_now != TBC_BC_W'(cur_b[TBC_PLEN_HI:TBC_PLEN_LO]));
  assign err_now  = b_err || len_bad;
  // a fresh packet starts without the error of an abandoned one
  assign eff_pkt_err = (b_take && first) ? 1'b0 : pkt_err;

  // position within the buffer: first word, second word, then payload and pad
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st     <= S_A;
      cmd_a  <= '0;
      idx    <= '0;
      total  <= '0;
      padded <= '0;
    end else if (accept) begin
      unique case (st)
        S_A: begin
          cmd_a <= link.word;
          st    <= S_B;
        end
        S_B: begin
          total  <= b_tot;
          padded <= b_pad;
          idx    <= '0;
          st     <= (b_pad == '0) ? S_A : S_PAY;
        end
        S_PAY: begin
          idx <= idx + 10'h001;
          if (idx == padded - 10'h001) begin
            st <= S_A;
          end
        end
      endcase
    end
  end

  // packet context: reference second word, byte total, open packet
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      b_ref    <= '0;
      byte_cnt <= '0;
      in_pkt   <= 1'b0;
    end else begin
      if (b_take) begin
        if (first) begin
          b_ref <= link.word;
        end
        byte_cnt <= next_bytes;
        in_pkt   <= 1'b1;
      end
      if (pkt_done) begin
        in_pkt <= 1'b0;
      end
    end
  end

  // errors collected over the packet for its completion status
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pkt_err <= 1'b0;
    end else if (pkt_done) begin
      pkt_err <= 1'b0;
    end else if (b_take) begin
      pkt_err <= eff_pkt_err || b_err;
    end
  end

  // completion status: tag unchanged plus error summary
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stat_word_out  <= '0;
      stat_valid_out <= 1'b0;
    end else begin
      stat_valid_out <= pkt_done;
      if (pkt_done) begin
        stat_word_out                        <= '0;
        stat_word_out[TBC_TAG_HI:TBC_TAG_LO] <= cur_b[TBC_TAG_HI:TBC_TAG_LO];
        stat_word_out[TBC_ST_ERR]            <= eff_pkt_err || err_now;
      end
    end
  end

  // sticky flags; a new event in the clearing cycle wins over the clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      err_flag  <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      if (err_now) begin
        err_flag <= 1'b1;
      end else if (link.flag_clr) begin
        err_flag <= 1'b0;
      end
      if (buf_end && ioc) begin
        done_flag <= 1'b1;
      end else if (link.flag_clr) begin
        done_flag <= 1'b0;
      end
    end
  end

  // interrupt follows the loaded flag one cycle later, gated by the mask
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq <= 1'b0;
    end else begin
      irq <= done_flag && link.irq_mask;
    end
  end

  assign link.err_flag  = err_flag;
  assign link.done_flag = done_flag;
  assign link.irq       = irq;

  // payload store; a full fifo holds the link, which is the host's back-pressure
  tbc_fifo #(
    .WIDTH (TBC_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .in_data_in    (link.word),
    .in_valid_in   (link.word_valid && keep),
    .in_ready_out  (fifo_ready),
    .out_data_out  (pay_data_out),
    .out_valid_out (pay_valid_out),
    .out_ready_in  (pay_ready_in)
  );
endmodule

/* File: logic/tbc_fifo.sv */
// module: small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module tbc_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // fill side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // drain side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             wr;
  logic             rd;

  function automatic logic [AW-1:0] tbc_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // full and empty come from the count alone, so ready never depends on valid
  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign wr            = in_valid_in && in_ready_out;
  assign rd            = out_valid_out && out_ready_in;

  // storage has no reset; only words behind count are ever read
  always_ff @(posedge clk_in) begin
    if (wr) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (wr) begin
        wr_ptr <= tbc_inc(wr_ptr);
      end
      if (rd) begin
        rd_ptr <= tbc_inc(rd_ptr);
      end
      if (wr && !rd) begin
        count <= count + 1'b1;
      end else if (rd && !wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* File: logic/tbc_host.sv */
// module: host controller end that sequences command, payload and pad words onto the link
`timescale 1ns/100ps
module tbc_host
  import tbc_pkg::*;
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // software register port
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [TBC_W-1:0] reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic [TBC_W-1:0]      reg_rdata_out,
  // word link to the device
  tbc_if.host                   link
);
  typedef enum logic [1:0] {H_A, H_B, H_PAY, H_PAD} tbc_hst_t;

  tbc_hst_t         hs;
  logic [TBC_W-1:0] cmd_a;
  logic [TBC_W-1:0] pend_word;
  logic             pend_valid;
  tbc_dw_t          remain;
  tbc_dw_t          pad_left;
  tbc_dw_t          tot;
  tbc_dw_t          pd;
  logic             irq_mask;
  logic             flag_clr;
  logic             order_err;
  logic             overrun;
  logic             wr_a;
  logic             wr_b;
  logic             wr_d;
  logic             take_a;
  logic             take_b;
  logic             take_d;
  logic             take_p;
  logic             bad_wr;
  logic             clr_host;
  logic [TBC_W-1:0] a_clean;

  assign wr_a = reg_wr_in && (reg_addr_in == TBC_REG_CMDA);
  assign wr_b = reg_wr_in && (reg_addr_in == TBC_REG_CMDB);
  assign wr_d = reg_wr_in && (reg_addr_in == TBC_REG_DATA);

  // a word is only loaded while the holding register is free
  assign take_a = wr_a && !pend_valid && (hs == H_A);
  assign take_b = wr_b && !pend_valid && (hs == H_B);
  assign take_d = wr_d && !pend_valid && (hs == H_PAY);
  assign take_p = !pend_valid && (hs == H_PAD);
  // out-of-order or early payload is dropped rather than corrupting the buffer
  assign bad_wr = (wr_a && hs != H_A) || (wr_b && hs != H_B) || (wr_d && hs != H_PAY);
  assign clr_host = reg_wr_in && (reg_addr_in == TBC_REG_CTRL) && reg_wdata_in[TBC_CB_CLRHOST];

  // reserved bits of the first word always go out as zero
  always_comb begin
    a_clean                        = reg_wdata_in;
    a_clean[TBC_RSV_HI:TBC_RSV_LO] = '0;
  end

  assign tot = tbc_buf_dwords(cmd_a[TBC_OFF_HI:TBC_OFF_LO], cmd_a[TBC_SIZE_HI:TBC_SIZE_LO]);
  assign pd  = tbc_padded(tot, cmd_a[TBC_ALIGN_HI:TBC_ALIGN_LO]);

  // buffer sequence: first word, second word, payload, then pad dwords
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hs       <= H_A;
      cmd_a    <= '0;
      remain   <= '0;
      pad_left <= '0;
    end else if (take_a) begin
      cmd_a <= a_clean;
      hs    <= H_B;
    end else if (take_b) begin
      remain   <= tot;
      pad_left <= pd - tot;
      hs       <= (tot == '0) ? H_A : H_PAY;
    end else if (take_d) begin
      remain <= remain - 10'h001;
      if (remain == 10'h001) begin
        hs <= (pad_left != '0) ? H_PAD : H_A;
      end
    end else if (take_p) begin
      pad_left <= pad_left - 10'h001;
      if (pad_left == 10'h001) begin
        hs <= H_A;
      end
    end
  end

  // holding register drives the link until the device takes the word
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_word  <= '0;
      pend_valid <= 1'b0;
    end else if (pend_valid) begin
      if (link.word_ready) begin
        pend_valid <= 1'b0;
      end
    end else if (take_a) begin
      pend_word  <= a_clean;
      pend_valid <= 1'b1;
    end else if (take_b || take_d) begin
      pend_word  <= reg_wdata_in;
      pend_valid <= 1'b1;
    end else if (take_p) begin
      pend_word  <= '0;
      pend_valid <= 1'b1;
    end
  end

  // host sticky errors; a new error beats a clear in the same cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      order_err <= 1'b0;
      overrun   <= 1'b0;
    end else begin
      if (bad_wr) begin
        order_err <= 1'b1;
      end else if (clr_host) begin
        order_err <= 1'b0;
      end
      if ((wr_a || wr_b || wr_d) && pend_valid) begin
        overrun <= 1'b1;
      end else if (clr_host) begin
        overrun <= 1'b0;
      end
    end
  end

  // control register: mask and one-cycle clear toward the device
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_mask <= TBC_MASK_RST;
      flag_clr <= 1'b0;
    end else begin
      flag_clr <= 1'b0;
      if (reg_wr_in && (reg_addr_in == TBC_REG_CTRL)) begin
        irq_mask <= reg_wdata_in[TBC_CB_MASK];
        flag_clr <= reg_wdata_in[TBC_CB_CLRDEV];
      end
    end
  end

  // read data stands for one cycle only; unmapped offsets read zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= '0;
      if (reg_rd_in && (reg_addr_in == TBC_REG_STAT)) begin
        reg_rdata_out[TBC_SB_ERR]   <= link.err_flag;
        reg_rdata_out[TBC_SB_DONE]  <= link.done_flag;
        reg_rdata_out[TBC_SB_IRQ]   <= link.irq;
        reg_rdata_out[TBC_SB_BUSY]  <= pend_valid;
        reg_rdata_out[TBC_SB_ORDER] <= order_err;
        reg_rdata_out[TBC_SB_OVRUN] <= overrun;
        reg_rdata_out[TBC_SB_IDLE]  <= (hs == H_A);
      end else if (reg_rd_in && (reg_addr_in == TBC_REG_CTRL)) begin
        reg_rdata_out[TBC_CB_MASK] <= irq_mask;
      end
    end
  end

  assign link.word       = pend_word;
  assign link.word_valid = pend_valid;
  assign link.flag_clr   = flag_clr;
  assign link.irq_mask   = irq_mask;
endmodule

/* File: logic/tbc_if.sv */
// interface: word link between host controller and parser
`timescale 1ns/100ps
interface tbc_if;
  import tbc_pkg::*;

  logic [TBC_W-1:0] word;
  logic             word_valid;
  logic             word_ready;
  logic             flag_clr;
  logic             irq_mask;
  logic             err_flag;
  logic             done_flag;
  logic             irq;

  modport dev (
    input  word, word_valid, flag_clr, irq_mask,
    output word_ready, err_flag, done_flag, irq
  );

  modport host (
    output word, word_valid, flag_clr, irq_mask,
    input  word_ready, err_flag, done_flag, irq
  );
endinterface

/* File: logic/tbc_pkg.sv */
// package: constants, field layout and shared arithmetic for the tx buffer command parser
package tbc_pkg;

  localparam int unsigned TBC_W          = 32;
  localparam int unsigned TBC_FIFO_DEPTH = 4;
  localparam int unsigned TBC_BC_W       = 16;

  // first command word fields
  localparam int TBC_IOC_BIT  = 31;
  localparam int TBC_RSV_HI   = 30;
  localparam int TBC_RSV_LO   = 26;
  localparam int TBC_ALIGN_HI = 25;
  localparam int TBC_ALIGN_LO = 24;
  localparam int TBC_OFF_HI   = 20;
  localparam int TBC_OFF_LO   = 16;
  localparam int TBC_FIRST    = 13;
  localparam int TBC_LAST     = 12;
  localparam int TBC_SIZE_HI  = 10;
  localparam int TBC_SIZE_LO  = 0;

  // second command word fields
  localparam int TBC_TAG_HI  = 31;
  localparam int TBC_TAG_LO  = 16;
  localparam int TBC_PLEN_HI = 10;
  localparam int TBC_PLEN_LO = 0;

  // completion status word
  localparam int TBC_ST_ERR = 15;

  // end alignment codes
  localparam logic [1:0] TBC_AL_4  = 2'h0;
  localparam logic [1:0] TBC_AL_16 = 2'h1;
  localparam logic [1:0] TBC_AL_32 = 2'h2;

  // host controller register offsets
  localparam logic [7:0] TBC_REG_CMDA = 8'h00;
  localparam logic [7:0] TBC_REG_CMDB = 8'h04;
  localparam logic [7:0] TBC_REG_DATA = 8'h08;
  localparam logic [7:0] TBC_REG_STAT = 8'h0c;
  localparam logic [7:0] TBC_REG_CTRL = 8'h10;

  // status register bits
  localparam int TBC_SB_ERR   = 0;
  localparam int TBC_SB_DONE  = 1;
  localparam int TBC_SB_IRQ   = 2;
  localparam int TBC_SB_BUSY  = 3;
  localparam int TBC_SB_ORDER = 4;
  localparam int TBC_SB_OVRUN = 5;
  localparam int TBC_SB_IDLE  = 6;

  // control register bits and reset value
  localparam int          TBC_CB_MASK    = 0;
  localparam int          TBC_CB_CLRDEV  = 1;
  localparam int          TBC_CB_CLRHOST = 2;
  localparam logic        TBC_MASK_RST   = 1'b0;

  typedef logic [9:0] tbc_dw_t;

  // dwords a buffer spans: offset bytes plus payload bytes, rounded up
  function automatic tbc_dw_t tbc_buf_dwords(input logic [4:0] off, input logic [10:0] size);
    logic [11:0] s;
    s = {7'h0, off} + {1'b0, size} + 12'h003;
    return s[11:2];
  endfunction

  // dwords after end padding to the requested alignment
  function automatic tbc_dw_t tbc_padded(input tbc_dw_t n, input logic [1:0] al);
    tbc_dw_t t;
    t = n;
    if (al == TBC_AL_16) begin
      t = (n + 10'h003) & 10'h3fc;
    end else if (al == TBC_AL_32) begin
      t = (n + 10'h007) & 10'h3f8;
    end
    return t;
  endfunction

endpackage

/* File: test/tb_top.sv */
// bench: random and corner packets through host controller and device
`timescale 1ns/100ps
module tb_top;
  import tbc_pkg::*;
  logic        clk_in, nrst_in, wr, rd, pay_valid, pay_ready, stat_valid, mask;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, pay_data, stat_word, seed, s;
  logic [31:0] exp_pay[$];
  logic [31:0] exp_st[$];
  int          bad_count, cmp_count, stall, i;

  tbc_if i_tbc_if ();
  tbc_host i_tbc_host (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .link(i_tbc_if));
  tbc_dev i_tbc_dev (.clk_in(clk_in), .nrst_in(nrst_in), .link(i_tbc_if),
    .pay_data_out(pay_data), .pay_valid_out(pay_valid), .pay_ready_in(pay_ready),
    .stat_word_out(stat_word), .stat_valid_out(stat_valid));
  tbc_link_assertions i_tbc_link_assertions (.clk_in(clk_in), .nrst_in(nrst_in),
    .word(i_tbc_if.word), .word_valid(i_tbc_if.word_valid),
    .word_ready(i_tbc_if.word_ready), .flag_clr(i_tbc_if.flag_clr),
    .irq_mask(i_tbc_if.irq_mask), .err_flag(i_tbc_if.err_flag),
    .done_flag(i_tbc_if.done_flag), .irq(i_tbc_if.irq));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task give_verdict();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task tmo();
    bad_count++;
    give_verdict();
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    d = rdata;
  endtask

  // word writes wait for busy low, a first word for idle too, as pad words run on their own
  task put(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    logic        w;
    int k;
    w = 1'b1;
    for (k = 0; k < 300 && w; k++) begin
      rd_reg(TBC_REG_STAT, t);
      w = (t[TBC_SB_BUSY] !== 1'b0) || (a == TBC_REG_CMDA && t[TBC_SB_IDLE] !== 1'b1);
    end
    if (w) tmo();
    wr_reg(a, d);
  endtask

  function automatic int ndw(input logic [31:0] a);
    return (a[20:16] + a[10:0] + 3) / 4;
  endfunction

  // dwords ahead of the start offset are dropped, the rest stored whole
  task send_buf(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    int j;
    put(TBC_REG_CMDA, a);
    put(TBC_REG_CMDB, b);
    for (j = 0; j < ndw(a); j++) begin
      d = rnd();
      put(TBC_REG_DATA, d);
      if (j >= a[20:18]) exp_pay.push_back(d); // stored payload
    end
  endtask

  // one packet of nb buffers; bb spoils the second tag, dl skews the length
  task pkt(input int nb, input logic bb, input logic [10:0] s0, input logic [10:0] dl);
    logic [31:0] a[2];
    logic [31:0] b;
    logic [10:0] len;
    logic        dn;
    int          j;
    len = dl;
    dn = 1'b0;
    for (j = 0; j < nb; j++) begin
      a[j] = rnd() & 32'hff1f_0000;
      a[j][13] = (j == 0);
      a[j][12] = (j == nb - 1);
      a[j][10:0] = (j == 0) ? s0 : 11'(rnd() & 32'h3f) + 11'h001;
      if (a[j][10:0] == 11'h0) a[j][20:16] = 5'h0;
      len += a[j][10:0];
      dn |= a[j][31];
    end
    b = {rnd() & 32'hffff_0000} | {21'h0, len};
    exp_st.push_back({b[31:16], bb | (dl != 11'h0), 15'h0});
    for (j = 0; j < nb; j++) send_buf(a[j], (bb && j == 1) ? b ^ 32'h0001_0000 : b);
    for (j = 0; j < 600 && (exp_pay.size() > 0 || exp_st.size() > 0); j++) @(posedge clk_in);
    if (j == 600) tmo();
    rd_reg(TBC_REG_STAT, s);
    chk({25'h0, s[6:0]}, {25'h0, 4'h8, dn & mask, dn, bb | (dl != 11'h0)});
    wr_reg(TBC_REG_CTRL, {30'h0, 1'b1, mask});
  endtask

  // far side drain: random stalls plus a long forced stall to fill the fifo
  always @(posedge clk_in) begin
    if (stall > 0) stall <= stall - 1;
    pay_ready <= (stall == 0) && (rnd() % 3 != 0);
  end

  // payload order and status word against expectation
  always @(posedge clk_in) begin
    if (pay_valid === 1'b1 && pay_ready === 1'b1) chk(pay_data, exp_pay.pop_front());
    if (stat_valid === 1'b1) chk(stat_word, exp_st.pop_front()); // tag and error
  end

  initial begin
    seed = 32'h7ff2936d;
    bad_count = 0;
    cmp_count = 0;
    stall = 0;
    mask = 1'b0;
    nrst_in = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    pay_ready = 1'b0;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd_reg(TBC_REG_CTRL, s);
    chk(s, 32'h0);
    rd_reg(TBC_REG_STAT, s);
    chk({25'h0, s[6:0]}, 32'h40);
    // payload with no command ahead of it is refused; unmapped write is harmless
    put(TBC_REG_DATA, 32'h5a5a_0001);
    wr_reg(8'h20, 32'hffff_ffff);
    rd_reg(TBC_REG_STAT, s);
    chk({31'h0, s[TBC_SB_ORDER]}, 32'h1); // out of sequence word
    wr_reg(TBC_REG_CTRL, 32'h4);
    // corners: empty buffer, stalled long buffer, two buffers, tag clash, bad length
    pkt(1, 1'b0, 11'h000, 11'h000);
    stall = 60;
    pkt(1, 1'b0, 11'h040, 11'h000);
    pkt(2, 1'b0, 11'h005, 11'h000);
    pkt(2, 1'b1, 11'h009, 11'h000);
    pkt(1, 1'b0, 11'h00c, 11'h003);
    for (i = 0; i < 14; i++) begin
      mask = rnd() % 2;
      wr_reg(TBC_REG_CTRL, {31'h0, mask});
      pkt(rnd() % 2 + 1, 1'b0, 11'(rnd() % 48) + 11'h001, 11'h000);
    end
    give_verdict();
  end
endmodule

/* File: test/tbc_link_assertions.sv */
// checker: word link protocol and flag timing between host controller and device
`timescale 1ns/100ps
module tbc_link_assertions
  import tbc_pkg::*;
(
  // clock and reset
  input wire logic             clk_in,
  input wire logic             nrst_in,
  // link signals
  input wire logic [TBC_W-1:0] word,
  input wire logic             word_valid,
  input wire logic             word_ready,
  input wire logic             flag_clr,
  input wire logic             irq_mask,
  input wire logic             err_flag,
  input wire logic             done_flag,
  input wire logic             irq
);
  logic [1:0]  ph;
  logic [31:0] a_q;
  logic [9:0]  rem;
  logic [9:0]  nd;
  logic [11:0] raw;
  logic        take;
  logic        fin;
  logic        fin_ioc;
  logic        err_cause;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // padded dword count announced by the held first word; own arithmetic, not the design's
  always_comb begin
    raw = {7'h0, a_q[20:16]} + {1'b0, a_q[10:0]} + 12'h003;
    nd = raw[11:2];
    if (a_q[25:24] == 2'h1) nd = (nd + 10'h003) & 10'h3fc;
    if (a_q[25:24] == 2'h2) nd = (nd + 10'h007) & 10'h3f8;
  end
  assign take = word_valid & word_ready;
  assign fin = take & ((ph == 2'h1 && nd == 10'h0) || (ph == 2'h2 && rem == 10'h001));
  assign fin_ioc = fin & a_q[31];
  assign err_cause = take & (ph == 2'h1 || fin);

  // buffer position: 0 first word, 1 second word, 2 padded dwords
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ph <= 2'h0;
      a_q <= 32'h0;
      rem <= 10'h0;
    end else if (take) begin
      if (ph == 2'h0) begin
        a_q <= word;
        ph <= 2'h1;
      end else if (ph == 2'h1) begin
        rem <= nd;
        ph <= (nd == 10'h0) ? 2'h0 : 2'h2;
      end else begin
        rem <= rem - 10'h001;
        if (rem == 10'h001) ph <= 2'h0;
      end
    end
  end

  property p_irq;
    1 |=> irq == $past(done_flag && irq_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not done and mask one cycle late");
  property p_done_hold;
    done_flag && !flag_clr |=> done_flag;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag dropped");
  property p_err_hold;
    err_flag && !flag_clr |=> err_flag;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
  property p_clr;
    flag_clr && !take |=> !done_flag && !err_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("flags survived clear");
  property p_done_set;
    fin_ioc |=> done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag missing");
  property p_done_cause;
    $rose(done_flag) |-> $past(fin_ioc);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done flag without cause");
  property p_err_cause;
    $rose(err_flag) |-> $past(err_cause);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("error flag out of place");
  property p_ready;
    ph != 2'h2 |-> word_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("command word refused");
  property p_hold;
    word_valid && !word_ready |=> word_valid && $stable(word);
  endproperty
  a_hold: assert property (p_hold) else $error("word changed while refused");
  property p_rsv;
    word_valid && ph == 2'h0 |-> word[30:26] == 5'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");

  c_stall: cover property (word_valid && !word_ready);
  c_done: cover property (fin_ioc);
  c_err: cover property ($rose(err_flag));
  c_irq: cover property (irq);
endmodule
